/* rtl/prox_int_core.sv */
// Proximity mode control, conversion timing and threshold interrupt
// What this block does
// - After power-up the block sits in standby until software sets active.
// - In standby no conversion runs and no new result is stored.
// - Registers stay readable and writable over I2C in standby.
// - Writing the restart bit returns every register to its power-on value.
// - Each result is captured a fixed number of cycles after its start.
// - Interrupt when a result lies above the upper or, in window type, below the lower limit.
// - Only a fresh result is compared; limit writes evaluate nothing.
// - Interrupt state shows on the pin and in a readable register.
// - Interrupt pin is enabled or disabled by register, apart from evaluation.
// - Asserted interrupt level on the pin is programmable low or high.
// - Software chooses window type or logic type interrupt.
// - Logic type needs control bit 2 and interrupt register bit 1 set.
// - Window type is default and reports no near or far transitions.
// - Four diode switch bits reset to one; upper bits read zero.
// - Three tuning registers reset to defaults and accept any value.
// - Interrupt mode 00 leaves pin released; 01 lets results trigger it.
// - Polarity 0 signals active low, polarity 1 active high.
// - Persistence N needs N consecutive out-of-range results on the same side; 0 means every.
// - Sixteen-bit limits in result format; upper resets ones, lower zeros.
`timescale 1ns/10ps
`default_nettype none
module prox_int_core
    import prox_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter logic [6:0] I2C_ADDR = DEF_I2C_ADDR
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic int_o,
    output logic int_oe_n,
    output logic conv_start,
    output logic measuring,
    input wire logic [15:0] adc_value,
    output afe_cfg_t afe_cfg
);
    // Conversion counter is 16 bits wide
    if (CONV_CYC < 1 || CONV_CYC > 65535)
    begin : g_bad_conv
        $error("CONV_CYC out of range");
    end

    localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);

    typedef struct packed {
        meas_state_t st;
        logic [15:0] cnt;
        logic conv_start;
        logic [7:0] ctrl;
        logic [7:0] intr;
        logic [3:0] persist;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] result;
        logic [3:0] diodes;
        logic [7:0] tune_a;
        logic [7:0] tune_b;
        logic [7:0] tune_c;
        logic [3:0] hits;
        logic last_above;
        logic int_act;
        logic near;
        logic far_to_near_report;
        logic near_to_far_report;
        logic pin;
    } core_t;

    localparam core_t CORE_RST = '{st: MS_STANDBY, cnt: 16'h0000,
        conv_start: 1'b0, ctrl: RST_CONTROL, intr: RST_INTR,
        persist: RST_PERSIST, upper: RST_UPPER, lower: RST_LOWER,
        result: 16'h0000, diodes: RST_DIODES, tune_a: RST_TUNE_A,
        tune_b: RST_TUNE_B, tune_c: RST_TUNE_C, hits: 4'h0,
        last_above: 1'b0, int_act: 1'b0, near: 1'b0, far_to_near_report: 1'b0,
        near_to_far_report: 1'b0, pin: 1'b1};

    core_t q, d;
    reg_wr_t wr;
    logic [7:0] rd_addr, rd_data;
    logic [15:0] val;
    logic above, below, outr, qual, logic_type;
    logic [3:0] hits_n;

    // Register access keeps working in every mode
    i2c_reg_slave #(
        .ADDR(I2C_ADDR)
    ) u_i2c (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Status byte shared by the read path
    function automatic logic [7:0] status_byte(input core_t s);
        logic [7:0] b;
        b = 8'h00;
        b[ST_INT] = s.int_act;
        b[ST_NEAR] = s.near;
        b[ST_FTN] = s.far_to_near_report;
        b[ST_NTF] = s.near_to_far_report;
        b[ST_BUSY] = (s.st == MS_CONVERT);
        return b;
    endfunction

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (rd_addr)
            OFS_CONTROL: rd_data = q.ctrl;
            OFS_STATUS: rd_data = status_byte(q);
            OFS_RESULT_LO: rd_data = q.result[7:0];
            OFS_RESULT_HI: rd_data = q.result[15:8];
            OFS_INTR: rd_data = q.intr;
            OFS_PERSIST: rd_data = {q.persist, 4'h0};
            OFS_UPPER_LO: rd_data = q.upper[7:0];
            OFS_UPPER_HI: rd_data = q.upper[15:8];
            OFS_LOWER_LO: rd_data = q.lower[7:0];
            OFS_LOWER_HI: rd_data = q.lower[15:8];
            OFS_DIODES: rd_data = {4'h0, q.diodes};
            OFS_TUNE_A: rd_data = q.tune_a;
            OFS_TUNE_B: rd_data = q.tune_b;
            OFS_TUNE_C: rd_data = q.tune_c;
            default: rd_data = 8'h00;
        endcase
    end

    // Next state: writes, sequencer, threshold evaluation, pin
    always_comb
    begin
        d = q;
        d.conv_start = 1'b0;
        val = adc_value;
        above = val > q.upper;
        below = val < q.lower;
        outr = above | below;
        if (!outr)
            hits_n = 4'h0;
        else if (q.hits != 4'h0 && above != q.last_above)
            hits_n = 4'h1;
        else if (q.hits == 4'hF)
            hits_n = 4'hF;
        else
            hits_n = q.hits + 4'h1;
        qual = outr && (hits_n >= q.persist);
        logic_type = q.ctrl[CTL_LOGIC] & q.intr[INT_MODE_LO];
        // Register writes; limits take effect on the next result only
        if (wr.en)
        begin
            case (wr.addr)
                OFS_CONTROL: d.ctrl = wr.data;
                OFS_STATUS:
                begin
                    d.far_to_near_report = q.far_to_near_report & ~wr.data[ST_FTN];
                    d.near_to_far_report = q.near_to_far_report & ~wr.data[ST_NTF];
                end
                OFS_INTR: d.intr = wr.data;
                OFS_PERSIST: d.persist = wr.data[7:PERS_LO];
                OFS_UPPER_LO: d.upper[7:0] = wr.data;
                OFS_UPPER_HI: d.upper[15:8] = wr.data;
                OFS_LOWER_LO: d.lower[7:0] = wr.data;
                OFS_LOWER_HI: d.lower[15:8] = wr.data;
                OFS_DIODES: d.diodes = wr.data[3:0];
                OFS_TUNE_A: d.tune_a = wr.data;
                OFS_TUNE_B: d.tune_b = wr.data;
                OFS_TUNE_C: d.tune_c = wr.data;
                default: d.ctrl = q.ctrl;
            endcase
        end
        // Measurement sequencer
        case (q.st)
            MS_STANDBY:
            begin
                if (q.ctrl[CTL_ACTIVE])
                begin
                    d.st = MS_CONVERT;
                    d.cnt = 16'h0000;
                    d.conv_start = 1'b1;
                end
            end
            MS_CONVERT:
            begin
                if (!q.ctrl[CTL_ACTIVE])
                    d.st = MS_STANDBY;
                else if (q.cnt == CONV_LAST)
                begin
                    // Fresh result: the only point of comparison
                    d.result = val;
                    d.hits = hits_n;
                    d.last_above = above;
                    d.cnt = 16'h0000;
                    d.conv_start = 1'b1;
                    if (logic_type)
                    begin
                        if (qual && above)
                            d.near = 1'b1;
                        else if (qual && below)
                            d.near = 1'b0;
                        d.int_act = d.near;
                        if (d.near && !q.near)
                            d.far_to_near_report = 1'b1;
                        if (!d.near && q.near)
                            d.near_to_far_report = 1'b1;
                    end
                    else if (!outr)
                        d.int_act = 1'b0;
                    else if (qual)
                        d.int_act = 1'b1;
                end
                else
                    d.cnt = q.cnt + 16'h0001;
            end
            default: d.st = MS_STANDBY;
        endcase
        // Pin level follows polarity; released when mode is 00
        d.pin = d.int_act ? d.intr[INT_POL] : ~d.intr[INT_POL];
        // Restart reloads the power-on state
        if (wr.en && wr.addr == OFS_CONTROL && wr.data[CTL_RESTART])
            d = CORE_RST;
    end

    // State register, frozen while ce is low
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            q <= CORE_RST;
        else if (ce)
            q <= d;
    end

    assign int_o = q.pin;
    assign int_oe_n = (q.intr[2:1] == INT_MODE_OFF);
    assign conv_start = q.conv_start;
    assign measuring = (q.st == MS_CONVERT);
    assign afe_cfg = '{diode_switches: q.diodes, tune_a: q.tune_a,
        tune_b: q.tune_b, tune_c: q.tune_c};
endmodule // prox_int_core
`default_nettype wire

/* rtl/prox_pkg.sv */
// Shared constants and types for the proximity interrupt block
package prox_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CONTROL = 8'h81;
    localparam logic [7:0] OFS_STATUS = 8'h82;
    localparam logic [7:0] OFS_RESULT_LO = 8'h88;
    localparam logic [7:0] OFS_RESULT_HI = 8'h89;
    localparam logic [7:0] OFS_INTR = 8'hA7;
    localparam logic [7:0] OFS_PERSIST = 8'hA8;
    localparam logic [7:0] OFS_UPPER_LO = 8'hA9;
    localparam logic [7:0] OFS_UPPER_HI = 8'hAA;
    localparam logic [7:0] OFS_LOWER_LO = 8'hAB;
    localparam logic [7:0] OFS_LOWER_HI = 8'hAC;
    localparam logic [7:0] OFS_DIODES = 8'hD8;
    localparam logic [7:0] OFS_TUNE_A = 8'hDB;
    localparam logic [7:0] OFS_TUNE_B = 8'hE3;
    localparam logic [7:0] OFS_TUNE_C = 8'hF9;
    // Field positions
    localparam int CTL_ACTIVE = 1;
    localparam int CTL_LOGIC = 2;
    localparam int CTL_RESTART = 7;
    localparam int INT_POL = 3;
    localparam int INT_MODE_LO = 1;
    localparam int PERS_LO = 4;
    localparam int ST_INT = 0;
    localparam int ST_NEAR = 1;
    localparam int ST_FTN = 2;
    localparam int ST_NTF = 3;
    localparam int ST_BUSY = 4;
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_INTR = 8'h40;
    localparam logic [3:0] RST_PERSIST = 4'h0;
    localparam logic [15:0] RST_UPPER = 16'hFFFF;
    localparam logic [15:0] RST_LOWER = 16'h0000;
    localparam logic [3:0] RST_DIODES = 4'hF;
    localparam logic [7:0] RST_TUNE_A = 8'h14;
    localparam logic [7:0] RST_TUNE_B = 8'h67;
    localparam logic [7:0] RST_TUNE_C = 8'h8F;
    localparam logic [1:0] INT_MODE_OFF = 2'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 10000;
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] DEF_I2C_ADDR = 7'h23;
    // Measurement sequencer states
    typedef enum logic [1:0] {
        MS_STANDBY = 2'b00,
        MS_CONVERT = 2'b01
    } meas_state_t;
    // Register write strobe with its data
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;
    // Settings handed to the analog front end
    typedef struct packed {
        logic [3:0] diode_switches;
        logic [7:0] tune_a;
        logic [7:0] tune_b;
        logic [7:0] tune_c;
    } afe_cfg_t;
endpackage

/* rtl/i2c_reg_slave.sv */
// I2C target that turns bus transfers into register reads and writes
`timescale 1ns/10ps
`default_nettype none
module i2c_reg_slave
    import prox_pkg::*;
#(
    parameter logic [6:0] ADDR = DEF_I2C_ADDR
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output reg_wr_t wr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_AACK = 3'b011,
        I_WDAT = 3'b010,
        I_WACK = 3'b110,
        I_RDAT = 3'b111,
        I_RACK = 3'b101
    } i2c_state_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        i2c_state_t st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic first;
        logic nack;
        logic oe_n;
        reg_wr_t wr;
    } i2c_t;

    localparam i2c_t I2C_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1,
        sda_f: 1'b1, st: I_IDLE, bits: 4'h0, sh: 8'h00, ptr: 8'h00,
        rw: 1'b0, first: 1'b0, nack: 1'b0, oe_n: 1'b1, wr: '0};

    i2c_t q, d;
    logic scl_n, sda_n, rise, fall;

    always_comb
    begin
        d = q;
        d.wr.en = 1'b0;
        // Three-stage sync; level accepted when stages two and three agree
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
        sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        d.scl_f = scl_n;
        d.sda_f = sda_n;
        rise = scl_n & ~q.scl_f;
        fall = ~scl_n & q.scl_f;
        if (q.scl_f && scl_n && q.sda_f && !sda_n)
        begin
            d.st = I_ADDR;
            d.bits = 4'h0;
            d.oe_n = 1'b1;
        end
        else if (q.scl_f && scl_n && !q.sda_f && sda_n)
        begin
            d.st = I_IDLE;
            d.oe_n = 1'b1;
        end
        else
        begin
            case (q.st)
                I_ADDR, I_WDAT:
                begin
                    if (rise)
                    begin
                        d.sh = {q.sh[6:0], sda_n};
                        d.bits = q.bits + 4'h1;
                    end
                    else if (fall && q.bits == 4'h8)
                    begin
                        if (q.st == I_ADDR)
                        begin
                            d.rw = q.sh[0];
                            d.oe_n = (q.sh[7:1] != ADDR);
                            d.st = (q.sh[7:1] == ADDR) ? I_AACK : I_IDLE;
                        end
                        else
                        begin
                            d.oe_n = 1'b0;
                            d.st = I_WACK;
                            if (q.first)
                                d.ptr = q.sh;
                            else
                            begin
                                d.wr = '{en: 1'b1, addr: q.ptr, data: q.sh};
                                d.ptr = q.ptr + 8'h01;
                            end
                        end
                    end
                end
                I_AACK, I_RACK:
                begin
                    if (rise)
                        d.nack = sda_n;
                    else if (fall)
                    begin
                        d.bits = 4'h0;
                        d.first = 1'b1;
                        if (q.st == I_RACK && q.nack)
                        begin
                            d.oe_n = 1'b1;
                            d.st = I_IDLE;
                        end
                        else if (q.rw)
                        begin
                            d.sh = rd_data;
                            d.oe_n = rd_data[7];
                            d.st = I_RDAT;
                        end
                        else
                        begin
                            d.oe_n = 1'b1;
                            d.st = I_WDAT;
                        end
                    end
                end
                I_WACK:
                begin
                    if (fall)
                    begin
                        d.oe_n = 1'b1;
                        d.bits = 4'h0;
                        d.first = 1'b0;
                        d.st = I_WDAT;
                    end
                end
                I_RDAT:
                begin
                    if (fall && q.bits == 4'h7)
                    begin
                        d.oe_n = 1'b1;
                        d.ptr = q.ptr + 8'h01;
                        d.st = I_RACK;
                    end
                    else if (fall)
                    begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe_n = q.sh[6];
                        d.bits = q.bits + 4'h1;
                    end
                end
                default:
                    d.oe_n = 1'b1;
            endcase
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            q <= I2C_RST;
        else if (ce)
            q <= d;
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = q.oe_n;
    assign wr = q.wr;
    assign rd_addr = q.ptr;
endmodule // i2c_reg_slave
`default_nettype wire

/* testbench/prox_props.sv */
// Port assertions for the proximity interrupt core
`timescale 1ns/10ps
`default_nettype none
module prox_props
    import prox_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic int_o,
    input wire logic int_oe_n,
    input wire logic conv_start,
    input wire logic measuring,
    input wire logic [15:0] adc_value,
    input wire afe_cfg_t afe_cfg
);
    int cnt_q;
    int cnt_d;
    // Enabled cycles since the last conversion start
    always_comb
    begin
        cnt_d = cnt_q;
        if (!measuring)
            cnt_d = 0;
        else if (ce)
            cnt_d = conv_start ? 1 : cnt_q + 1;
    end
    // Counter register, cleared in reset
    always_ff @(posedge sys_clk)
    begin
        cnt_q <= rstn ? cnt_d : 0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // First edge after a reset that took effect
    sequence s_rel;
        $rose(rstn) && $past(ce);
    endsequence
    chk_reset_idle: assert property (s_rel |-> !measuring
        && !conv_start && int_oe_n && sda_oe_n)
        else $error("outputs not idle after reset");
    chk_reset_afe: assert property (s_rel |-> afe_cfg ==
        {RST_DIODES, RST_TUNE_A, RST_TUNE_B, RST_TUNE_C})
        else $error("front end settings not at defaults");
    chk_conv_period: assert property (ce && conv_start && cnt_q != 0
        |-> cnt_q == CONV_CYC) else $error("conversion period wrong");
    chk_conv_bound: assert property (cnt_q <= CONV_CYC)
        else $error("conversion overran");
    chk_standby_quiet: assert property (conv_start |-> measuring)
        else $error("conversion start in standby");
    chk_meas_begins: assert property ($rose(measuring) |-> conv_start)
        else $error("measurement began without start");
    // Data pin only pulls low, and only moves while the bus clock is low
    chk_sda_drain: assert property (!sda_o
        && (!$changed(sda_oe_n) || !scl_i))
        else $error("data pin moved while clock high");
    chk_ce_freeze: assert property (!ce |=> $stable(measuring)
        && $stable(int_o) && $stable(afe_cfg))
        else $error("state moved with clock enable low");
endmodule // prox_props

bind prox_int_core prox_props #(.CONV_CYC(CONV_CYC)) u_props (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .int_o(int_o),
    .int_oe_n(int_oe_n), .conv_start(conv_start),
    .measuring(measuring), .adc_value(adc_value), .afe_cfg(afe_cfg));
`default_nettype wire

/* testbench/i2c_host_model.sv */
// Host bus controller model driving the I2C pins
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model
(
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    // Both lines start released; data is open drain, 1 releases
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One bit: data set in low phase, line sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        tick(5);
        scl = 1'b1;
        tick(5);
        r = sda_line;
        tick(5);
        scl = 1'b0;
        tick(5);
    endtask
    // Start or repeated start, ends with clock low
    task automatic start();
        sda = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(5);
        sda = 1'b0;
        tick(5);
        scl = 1'b0;
        tick(5);
    endtask
    // Stop, then bus free time
    task automatic stop();
        sda = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(5);
        sda = 1'b1;
        tick(10);
    endtask
    // Eight bits out and in, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic nine,
        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(nine, r);
        ack = !r;
    endtask
endmodule // i2c_host_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the proximity interrupt core
`timescale 1ns/10ps
`default_nettype none
module tb
    import prox_pkg::*;
;
    localparam int CC = 4;
    localparam logic [7:0] DEV_W = {DEF_I2C_ADDR, 1'b0};
    typedef struct packed {
        logic we;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] adc_value = 16'h0000;
    logic scl, sda_h, sda_o, sda_oe_n, int_o, int_oe_n;
    logic conv_start, measuring;
    afe_cfg_t afe_cfg;
    wire logic sda_line = sda_h & (sda_oe_n | sda_o);
    int n_fail = 0;
    int check_count = 0;
    logic [7:0] rd;
    // Reset values, writes, unmapped place
    row_t rows[16] = '{
        '{1'b0, 8'hD8, 8'h00, 8'h0F}, '{1'b0, 8'hDB, 8'h00, 8'h14},
        '{1'b0, 8'hE3, 8'h00, 8'h67}, '{1'b0, 8'hF9, 8'h00, 8'h8F},
        '{1'b0, 8'hA7, 8'h00, 8'h40}, '{1'b0, 8'hA9, 8'h00, 8'hFF},
        '{1'b0, 8'hAA, 8'h00, 8'hFF}, '{1'b0, 8'hAB, 8'h00, 8'h00},
        '{1'b0, 8'hAC, 8'h00, 8'h00}, '{1'b0, 8'hA8, 8'h00, 8'h00},
        '{1'b0, 8'h88, 8'h00, 8'h00}, '{1'b1, 8'hDB, 8'h5A, 8'h5A},
        '{1'b1, 8'hE3, 8'hA5, 8'hA5}, '{1'b1, 8'hF9, 8'h3C, 8'h3C},
        '{1'b1, 8'hD8, 8'h05, 8'h05}, '{1'b1, 8'h90, 8'h55, 8'h00}};
    always #50 sys_clk = ~sys_clk;
    prox_int_core #(.CONV_CYC(CC)) u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .int_o(int_o), .int_oe_n(int_oe_n), .conv_start(conv_start),
        .measuring(measuring), .adc_value(adc_value), .afe_cfg(afe_cfg));
    i2c_host_model u_host (.sys_clk(sys_clk), .sda_line(sda_line),
        .scl(scl), .sda(sda_h));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Register write: address, pointer, one data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic [2:0] k;
        u_host.start();
        u_host.xfer(DEV_W, 1'b1, q, k[2]);
        u_host.xfer(a, 1'b1, q, k[1]);
        u_host.xfer(d, 1'b1, q, k[0]);
        u_host.stop();
        check("write ack", k, 3'b111);
    endtask
    // Register read: pointer, repeated start, one byte, no ack
    task automatic rdr(input logic [7:0] a, output logic [7:0] v);
        logic [7:0] q;
        logic [2:0] k;
        logic n;
        u_host.start();
        u_host.xfer(DEV_W, 1'b1, q, k[2]);
        u_host.xfer(a, 1'b1, q, k[1]);
        u_host.start();
        u_host.xfer(DEV_W | 8'h01, 1'b1, q, k[0]);
        u_host.xfer(8'hFF, 1'b1, v, n);
        u_host.stop();
        check("read ack", k, 3'b111);
        check("read release", n, 1'b0);
    endtask
    // Wait for n conversion starts, bounded
    task automatic caps(input int n);
        int k;
        k = 0;
        for (int i = 0; i < 200 && k < n; i++)
        begin
            @(negedge sys_clk);
            if (conv_start === 1'b1)
                k++;
        end
        if (k < n)
        begin
            n_fail++;
            final_report();
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(negedge sys_clk);
            check("idle start", conv_start, 1'b0);
        end
        foreach (rows[i])
        begin
            if (rows[i].we)
                wr(rows[i].a, rows[i].d);
            rdr(rows[i].a, rd);
            check("reg", rd, rows[i].e);
        end
        check("afe", afe_cfg, 28'h55AA53C);
        wr(OFS_UPPER_LO, 8'h00);
        wr(OFS_UPPER_HI, 8'h01);
        wr(OFS_LOWER_LO, 8'h80);
        wr(OFS_INTR, 8'h42);
        check("pin on", int_oe_n, 1'b0);
        adc_value = 16'h0200;
        wr(OFS_CONTROL, 8'h02);
        caps(2);
        check("above", int_o, 1'b0);
        rdr(OFS_STATUS, rd);
        check("status", {rd[3:2], rd[0]}, 3'b001);
        adc_value = 16'h00C0;
        caps(2);
        check("inside", int_o, 1'b1);
        adc_value = 16'h0010;
        caps(2);
        check("below", int_o, 1'b0);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_LOWER_LO, 8'h00);
        check("old result", int_o, 1'b0);
        check("standby", measuring, 1'b0);
        rdr(OFS_RESULT_LO, rd);
        check("result", rd, 8'h10);
        wr(OFS_INTR, 8'h4A);
        check("high active", int_o, 1'b1);
        wr(OFS_INTR, 8'h48);
        check("pin off", int_oe_n, 1'b1);
        rdr(OFS_STATUS, rd);
        check("int bit", rd[0], 1'b1);
        wr(OFS_LOWER_LO, 8'h80);
        wr(OFS_INTR, 8'h42);
        wr(OFS_PERSIST, 8'h30);
        adc_value = 16'h00C0;
        wr(OFS_CONTROL, 8'h02);
        caps(2);
        check("cleared", int_o, 1'b1);
        adc_value = 16'h0200;
        for (int i = 1; i <= 3; i++)
        begin
            caps(1);
            check("persist", int_o, i != 3);
        end
        rdr(OFS_STATUS, rd);
        check("no flags", rd[3:2], 2'b00);
        wr(OFS_PERSIST, 8'h00);
        wr(OFS_CONTROL, 8'h06);
        adc_value = 16'h00C0;
        caps(2);
        check("logic hold", int_o, 1'b0);
        adc_value = 16'h0010;
        caps(2);
        check("far", int_o, 1'b1);
        rdr(OFS_STATUS, rd);
        check("far flag", rd[3:2], 2'b11);
        wr(OFS_STATUS, 8'h0C);
        rdr(OFS_STATUS, rd);
        check("flags clear", rd[3:2], 2'b00);
        ce = 1'b0;
        repeat (20) @(negedge sys_clk);
        ce = 1'b1;
        wr(OFS_CONTROL, 8'h80);
        check("restart", {measuring, int_oe_n, afe_cfg},
            {2'b01, 28'hF14678F});
        rdr(OFS_DIODES, rd);
        check("diodes", rd, 8'h0F);
        rstn = 1'b0;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        check("reset", {measuring, int_oe_n}, 2'b01);
        final_report();
    end
endmodule // tb
`default_nettype wire
